// ---- hdl/pbm_consts.svh ----
// constants of the packet buffer manager
`ifndef PBM_CONSTS_SVH
`define PBM_CONSTS_SVH

// smallest total memory, shifted left by the size code
`define MEM_MIN_BYTES 17'h02000
// one 2 kbyte transmit bank, shifted by the bank size code less one
`define BANK_MIN_BYTES 17'h00800
// receive header length in bytes
`define RX_HDR_BYTES 16'h0004
// receive frames start on this alignment
`define ALIGN_ADD 16'h0007
`define ALIGN_MASK 16'hfff8
// shortest legal frame, without preamble and crc
`define RUNT_MIN 16'h003c
// memory access time in ns and in clock cycles (at least one)
`define ACC_NS 80
`define CLK_NS 40
`define ACC_CYC 2'((`ACC_NS + `CLK_NS - 1) / `CLK_NS)
// pointer reset value and header byte positions
`define PTR_RST 16'h0000
`define HDR_STATUS 2'h0
`define HDR_LEN_HI 2'h2
`define HDR_LEN_LO 2'h3

`endif

// ---- hdl/pbm_pkg.sv ----
// types of the packet buffer manager
package pbm_pkg;

  typedef enum logic [0:0] {M_IDLE, M_ACC} mem_e;
  typedef enum logic [2:0] {O_RX, O_RXH, O_TX, O_HW, O_HR} owner_e;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_HDR, RX_DROP} rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_HDR0, TX_HDR1, TX_DATA} tx_e;

  // static memory pins
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we_n;
    logic        oe_n;
  } sram_s;

  // whole state of the manager
  typedef struct packed {
    mem_e        ms;
    owner_e      own;
    logic [1:0]  acc;
    sram_s       sram;
    logic        fill;
    logic [15:0] hwp;
    logic        hw_full;
    logic [7:0]  hw_d;
    logic        hw_rdy;
    logic        launch_rdy;
    tx_e         txs;
    logic [6:0]  frames;
    logic [15:0] tp;
    logic [15:0] tfs;
    logic [15:0] trem;
    logic        tx_valid;
    logic        tx_last;
    logic [7:0]  tx_data;
    logic        tx_flush;
    logic        tx_busy;
    logic        tirq;
    rx_e         rxs;
    logic        init;
    logic [15:0] wp;
    logic [15:0] rfs;
    logic [15:0] rlen;
    logic [15:0] used;
    logic [7:0]  rst;
    logic        rh_full;
    logic [7:0]  rh_d;
    logic        rx_rdy;
    logic [1:0]  hidx;
    logic [7:0]  rxf;
    logic        pend;
    logic        rirq;
    logic [15:0] rp;
    logic [15:0] rrs;
    logic [15:0] rcnt;
    logic [15:0] rrlen;
    logic        hr_pend;
    logic [7:0]  hr_d;
    logic        hr_val;
    logic        hr_rdy;
  } st_s;

endpackage

// ---- hdl/packet_buffer_manager.sv ----
// packet buffer manager: transmit banks, receive ring, memory arbiter
`timescale 1ns/1ps
`include "pbm_consts.svh"

// Contract
// - memory of 8, 16, 32 or 64 kbytes
// - bank code picks 2k single or pairs
// - send queued frames, then stop and flag
// - launch swaps banks (two-bank layout only), transmit starts promptly
// - host writes only advance write pointer
// - reset points host writes at bank start
// - collision resends same frame from bank
// - rest of memory is receive ring
// - receive frames start eight-byte aligned
// - read pointer wraps like write pointer
// - four-byte header, length gives next start
// - ring size is memory minus transmit
// - pending flag; host reads free space (no port here; used count stays internal)
// - drop frame lacking room, never overwrite
// - bad frames dropped unless kept, flagged
// - runts kept only when enabled
// - arbiter interleaves all four transfer kinds
// - host port through one-byte holding stages, sram strobes
// - signal host when a frame arrives
// - header holds status, zero, byte count
// - ring stores frames without preamble, crc
module packet_buffer_manager
  import pbm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  mem_size,
  input  wire logic        bank_size_hi,
  input  wire logic        bank_size_lo,
  input  wire logic        keep_errored,
  input  wire logic        keep_runts,
  input  wire logic        tx_irq_en,
  input  wire logic        host_wr,
  input  wire logic [7:0]  host_wdata,
  output logic             host_wr_ready,
  input  wire logic        host_rd,
  output logic             host_rd_ready,
  output logic [7:0]       host_rdata,
  output logic             host_rd_valid,
  input  wire logic        launch,
  input  wire logic [6:0]  queued_frame_count,
  output logic             launch_ready,
  output logic             tx_busy,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  output logic             tx_last,
  input  wire logic        tx_ready,
  input  wire logic        tx_collision,
  output logic             tx_irq,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_end,
  input  wire logic        rx_bad,
  input  wire logic [7:0]  rx_status,
  output logic             rx_ready,
  output logic             rx_pending,
  output logic             rx_irq,
  output sram_s            sram,
  input  wire logic [7:0]  sram_rdata
);

  //////////////////////////////////////////////////////////////////////
  // helpers

  // round a length up to the receive alignment
  function automatic logic [15:0] align8(input logic [15:0] x);
    align8 = (x + `ALIGN_ADD) & `ALIGN_MASK;
  endfunction

  // advance a pointer inside the ring, wrapping from top to base
  function automatic logic [15:0] ring_add(input logic [15:0] p,
                                           input logic [15:0] n,
                                           input logic [15:0] base,
                                           input logic [15:0] top);
    logic [16:0] s;
    s = {1'b0, p} + {1'b0, n};
    if (s > {1'b0, top}) begin
      s = s - {1'b0, top} - 17'h00001 + {1'b0, base};
    end
    ring_add = s[15:0];
  endfunction

  //////////////////////////////////////////////////////////////////////
  // memory layout

  logic [1:0]  bank_code;
  logic [16:0] mem_bytes;
  logic [16:0] bank_bytes;
  logic [16:0] tx_bytes;
  logic [16:0] ring_bytes;
  logic [15:0] top;
  logic [15:0] rx_base;
  logic        two_banks;

  always_comb begin
    bank_code  = {bank_size_hi, bank_size_lo};
    two_banks  = (bank_code != 2'h0);
    mem_bytes  = `MEM_MIN_BYTES << mem_size;
    bank_bytes = two_banks ? (`BANK_MIN_BYTES << (bank_code - 2'h1))
                           : `BANK_MIN_BYTES;
    tx_bytes   = two_banks ? (bank_bytes << 1) : bank_bytes;
    ring_bytes = mem_bytes - tx_bytes;
    top        = 16'(mem_bytes - 17'h00001);
    rx_base    = tx_bytes[15:0];
  end

  //////////////////////////////////////////////////////////////////////
  // state

  st_s st;
  st_s next_st;

  logic        need_rx;
  logic        need_rxh;
  logic        need_tx;
  logic        need_hw;
  logic        need_hr;
  logic [15:0] span;
  logic [15:0] rspan;
  logic [7:0]  hdr_byte;

  always_comb begin
    next_st = st;
    span    = align8(`RX_HDR_BYTES + st.rlen);
    rspan   = align8(`RX_HDR_BYTES + st.rrlen);
    next_st.tirq   = 1'b0;
    next_st.rirq   = 1'b0;
    next_st.hr_val = 1'b0;

    // header bytes: status, unused, length high, length low
    unique case (st.hidx)
      `HDR_STATUS: hdr_byte = st.rst;
      `HDR_LEN_HI: hdr_byte = st.rlen[15:8];
      `HDR_LEN_LO: hdr_byte = st.rlen[7:0];
      default:     hdr_byte = 8'h00;
    endcase

    // host write only captured, pointer moves when stored
    if (host_wr && st.hw_rdy) begin
      next_st.hw_full = 1'b1;
      next_st.hw_d    = host_wdata;
    end
    // host read request, one byte at a time
    if (host_rd && st.hr_rdy) begin
      next_st.hr_pend = 1'b1;
    end

    // launch swaps banks at once in the two-bank layout
    if (launch && st.launch_rdy && queued_frame_count != 7'h00) begin
      next_st.tp      = st.fill ? bank_bytes[15:0] : `PTR_RST;
      next_st.tfs     = st.fill ? bank_bytes[15:0] : `PTR_RST;
      next_st.frames  = queued_frame_count;
      next_st.tx_busy = 1'b1;
      next_st.txs     = TX_HDR0;
      if (two_banks) begin
        next_st.fill = ~st.fill;
        next_st.hwp  = st.fill ? `PTR_RST : bank_bytes[15:0];
      end else begin
        next_st.hwp  = `PTR_RST;
      end
    end

    // frame handed over; stop and flag after the last one
    if (st.tx_valid && tx_ready) begin
      next_st.tx_valid = 1'b0;
      if (st.tx_last) begin
        next_st.tfs    = st.tp;
        next_st.frames = st.frames - 7'h01;
        if (st.frames == 7'h01) begin
          next_st.txs     = TX_IDLE;
          next_st.tx_busy = 1'b0;
          next_st.tirq    = tx_irq_en;
        end else begin
          next_st.txs = TX_HDR0;
        end
      end
    end

    // receiver side: frame start, data, end of frame
    unique case (st.rxs)
      RX_IDLE: begin
        if (st.init) begin
          next_st.wp   = rx_base;
          next_st.rp   = rx_base;
          next_st.rrs  = rx_base;
          next_st.init = 1'b0;
        end else if (rx_valid && st.rx_rdy) begin
          // frame starts at the aligned write pointer
          next_st.rfs     = st.wp;
          next_st.rlen    = 16'h0001;
          // even the first byte needs room, else the oldest frame is hit
          if ({1'b0, st.used} + {1'b0, align8(`RX_HDR_BYTES + 16'h0001)} > ring_bytes) begin
            next_st.rxs = RX_DROP;
          end else begin
            next_st.wp      = ring_add(st.wp, `RX_HDR_BYTES, rx_base, top);
            next_st.rh_full = 1'b1;
            next_st.rh_d    = rx_data;
            next_st.rxs     = RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (rx_valid && st.rx_rdy) begin
          // room for the frame so far, else give it up
          if ({1'b0, st.used} + {1'b0, align8(`RX_HDR_BYTES + st.rlen
              + 16'h0001)} > ring_bytes) begin
            next_st.wp  = st.rfs;
            next_st.rxs = RX_DROP;
          end else begin
            next_st.rlen    = st.rlen + 16'h0001;
            next_st.rh_full = 1'b1;
            next_st.rh_d    = rx_data;
          end
        end else if (rx_end && st.rx_rdy) begin
          if ((rx_bad && !keep_errored) ||
              (st.rlen < `RUNT_MIN && !keep_runts)) begin
            next_st.wp  = st.rfs;
            next_st.rxs = RX_IDLE;
          end else begin
            next_st.rst  = rx_status;
            next_st.hidx = 2'h0;
            next_st.rxs  = RX_HDR;
          end
        end
      end
      RX_HDR: begin
      end
      RX_DROP: begin
        if (rx_end && st.rx_rdy) begin
          next_st.rxs = RX_IDLE;
        end
      end
    endcase

    // requests of all four transfer kinds
    need_rx  = st.rxs == RX_DATA && st.rh_full;
    need_rxh = st.rxs == RX_HDR;
    need_tx  = st.txs != TX_IDLE && !st.tx_valid && !st.tx_flush &&
               (st.txs != TX_DATA || st.trem != 16'h0000);
    need_hw  = st.hw_full;
    need_hr  = st.hr_pend;

    unique case (st.ms)
      M_IDLE: begin
        next_st.acc = `ACC_CYC - 2'h1;
        // receiver first, transmitter next, host last
        // address, data and strobe set for the whole access
        if (need_rx || need_rxh) begin
          next_st.ms         = M_ACC;
          next_st.own        = need_rx ? O_RX : O_RXH;
          next_st.sram.we_n  = 1'b0;
          next_st.sram.addr  = need_rx ? st.wp
                             : ring_add(st.rfs, {14'h0000, st.hidx}, rx_base, top);
          next_st.sram.wdata = need_rx ? st.rh_d : hdr_byte;
        end else if (need_tx) begin
          next_st.ms        = M_ACC;
          next_st.own       = O_TX;
          next_st.sram.oe_n = 1'b0;
          next_st.sram.addr = st.tp;
        end else if (need_hw) begin
          // host data reaches sram through its holding stage
          next_st.ms         = M_ACC;
          next_st.own        = O_HW;
          next_st.sram.we_n  = 1'b0;
          next_st.sram.addr  = st.hwp;
          next_st.sram.wdata = st.hw_d;
        end else if (need_hr) begin
          next_st.ms        = M_ACC;
          next_st.own       = O_HR;
          next_st.sram.oe_n = 1'b0;
          next_st.sram.addr = st.rp;
        end
      end
      M_ACC: begin
        if (st.acc != 2'h0) begin
          next_st.acc = st.acc - 2'h1;
        end else begin
          // access ends: strobes released, owner sees the result
          next_st.ms        = M_IDLE;
          next_st.sram.we_n = 1'b1;
          next_st.sram.oe_n = 1'b1;
          unique case (st.own)
            O_RX: begin
              // only frame body bytes arrive from the mac
              // write pointer wraps into the ring base
              next_st.rh_full = 1'b0;
              next_st.wp      = ring_add(st.wp, 16'h0001, rx_base, top);
            end
            O_RXH: begin
              next_st.hidx = st.hidx + 2'h1;
              if (st.hidx == `HDR_LEN_LO) begin
                // stored length sets the next frame start
                next_st.wp   = ring_add(st.rfs, span, rx_base, top);
                next_st.used = st.used + span;
                next_st.rxf  = st.rxf + 8'h01;
                next_st.rirq = 1'b1;
                next_st.rxs  = RX_IDLE;
              end
            end
            O_TX: begin
              if (st.tx_flush) begin
                next_st.tx_flush = 1'b0;
              end else begin
                next_st.tp = st.tp + 16'h0001;
                // two-byte length ahead of each frame, not sent
                unique case (st.txs)
                  TX_HDR0: begin
                    next_st.trem[15:8] = sram_rdata;
                    next_st.txs        = TX_HDR1;
                  end
                  TX_HDR1: begin
                    next_st.trem[7:0] = sram_rdata;
                    next_st.txs       = TX_DATA;
                  end
                  default: begin
                    next_st.tx_valid = 1'b1;
                    next_st.tx_data  = sram_rdata;
                    next_st.tx_last  = (st.trem == 16'h0001);
                    next_st.trem     = st.trem - 16'h0001;
                  end
                endcase
              end
            end
            O_HW: begin
              next_st.hw_full = 1'b0;
              next_st.hwp     = st.hwp + 16'h0001;
            end
            default: begin
              next_st.hr_pend = 1'b0;
              next_st.hr_d    = sram_rdata;
              next_st.hr_val  = 1'b1;
              next_st.rcnt    = st.rcnt + 16'h0001;
              // each byte read frees its space
              next_st.used    = st.used - 16'h0001;
              if (st.rcnt == 16'(`HDR_LEN_HI)) begin
                next_st.rrlen[15:8] = sram_rdata;
              end
              if (st.rcnt == 16'(`HDR_LEN_LO)) begin
                next_st.rrlen[7:0] = sram_rdata;
              end
              if (st.rcnt > 16'(`HDR_LEN_LO) &&
                  st.rcnt == 16'(`HDR_LEN_LO) + st.rrlen) begin
                // skip the pad and wrap to the next frame
                next_st.rp   = ring_add(st.rrs, rspan, rx_base, top);
                next_st.rrs  = ring_add(st.rrs, rspan, rx_base, top);
                next_st.used = st.used - (rspan - `RX_HDR_BYTES - st.rrlen) - 16'h0001;
                next_st.rcnt = 16'h0000;
                next_st.rxf  = st.rxf - 8'h01;
              end else begin
                next_st.rp = ring_add(st.rp, 16'h0001, rx_base, top);
              end
            end
          endcase
        end
      end
    endcase

    // collision rewinds to the frame start; mac times the backoff
    // after the arbiter, so it wins over a read ending or granted this cycle
    if (tx_collision && st.txs != TX_IDLE) begin
      next_st.tp       = st.tfs;
      next_st.txs      = TX_HDR0;
      next_st.tx_valid = 1'b0;
      next_st.tx_flush = (next_st.ms == M_ACC && next_st.own == O_TX);
    end

    // registered readiness and status, taken from the next state
    next_st.hw_rdy     = !next_st.hw_full;
    next_st.hr_rdy     = !next_st.hr_pend && next_st.rxf != 8'h00;
    next_st.launch_rdy = next_st.txs == TX_IDLE && !next_st.hw_full;
    next_st.rx_rdy     = !next_st.init && !next_st.rh_full &&
                         next_st.rxs != RX_HDR;
    next_st.pend       = next_st.rxf != 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // registers; reset points host writes at the start of bank zero

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st            <= '0;
      st.ms         <= M_IDLE;
      st.own        <= O_RX;
      st.txs        <= TX_IDLE;
      st.rxs        <= RX_IDLE;
      st.sram.we_n  <= 1'b1;
      st.sram.oe_n  <= 1'b1;
      st.hwp        <= `PTR_RST;
      st.init       <= 1'b1;
      st.hw_rdy     <= 1'b1;
      st.launch_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign host_wr_ready = st.hw_rdy;
  assign host_rd_ready = st.hr_rdy;
  assign host_rdata    = st.hr_d;
  assign host_rd_valid = st.hr_val;
  assign launch_ready  = st.launch_rdy;
  assign tx_busy       = st.tx_busy;
  assign tx_data       = st.tx_data;
  assign tx_valid      = st.tx_valid;
  assign tx_last       = st.tx_last;
  assign tx_irq        = st.tirq;
  assign rx_ready      = st.rx_rdy;
  assign rx_pending    = st.pend;
  assign rx_irq        = st.rirq;
  assign sram          = st.sram;

endmodule

// ---- sim/pbm_monitor.sv ----
// port assertions for the packet buffer manager
`timescale 1ns/1ps
module pbm_monitor
  import pbm_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       tx_irq_en,
  input wire logic       host_wr,
  input wire logic       host_wr_ready,
  input wire logic       host_rd,
  input wire logic       host_rd_ready,
  input wire logic       host_rd_valid,
  input wire logic       launch,
  input wire logic [6:0] queued_frame_count,
  input wire logic       launch_ready,
  input wire logic       tx_busy,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       tx_collision,
  input wire logic       tx_irq,
  input wire logic       rx_pending,
  input wire logic       rx_irq,
  input wire sram_s      sram
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // one memory access: strobe low two cycles, then released
  sequence s_write;
    !sram.we_n ##1 !sram.we_n ##1 sram.we_n;
  endsequence
  sequence s_read;
    !sram.oe_n ##1 !sram.oe_n ##1 sram.oe_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // reset is checked with no disable, since it is the cause here
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=>
    sram.we_n && sram.oe_n && !tx_irq && !rx_irq && launch_ready && host_wr_ready)
    else $error("outputs not idle in reset");
  a_write_len: assert property ($fell(sram.we_n) |-> s_write)
    else $error("write strobe length wrong");
  a_read_len: assert property ($fell(sram.oe_n) |-> s_read)
    else $error("read strobe length wrong");
  a_strobe_excl: assert property (sram.we_n || sram.oe_n)
    else $error("read and write strobes together");
  a_idle_gap: assert property ($rose(sram.we_n) || $rose(sram.oe_n) |->
    sram.we_n && sram.oe_n)
    else $error("no idle cycle between accesses");
  a_addr_hold: assert property ($fell(sram.we_n) || $fell(sram.oe_n) |=>
    $stable(sram.addr) && (sram.we_n || $stable(sram.wdata)))
    else $error("address or data moved in an access");
  a_launch_start: assert property (launch && launch_ready && queued_frame_count != 7'h00
    |=> tx_busy && !launch_ready)
    else $error("launch did not start transmit");
  a_host_write: assert property (host_wr && host_wr_ready |=>
    !host_wr_ready ##[1:40] host_wr_ready)
    else $error("host write not completed");
  a_read_answer: assert property (host_rd && host_rd_ready |=>
    !host_rd_ready ##[1:40] host_rd_valid)
    else $error("host read not answered");
  a_tx_hold: assert property (tx_valid && !tx_ready && !tx_collision |=>
    tx_valid && $stable(tx_data))
    else $error("transmit byte dropped before taken");
  a_tx_done: assert property ($rose(tx_irq) |-> tx_irq_en && !tx_busy ##1 !tx_irq)
    else $error("transmit done pulse wrong");
  a_rx_notice: assert property ($rose(rx_pending) |-> rx_irq)
    else $error("frame pending without notice");
endmodule

bind packet_buffer_manager pbm_monitor pbm_monitor_i (
  .clk, .rstn, .tx_irq_en, .host_wr, .host_wr_ready, .host_rd, .host_rd_ready,
  .host_rd_valid, .launch, .queued_frame_count, .launch_ready, .tx_busy, .tx_data,
  .tx_valid, .tx_ready, .tx_collision, .tx_irq, .rx_pending, .rx_irq, .sram
);

// ---- sim/sram_model.sv ----
// behavioural packet memory on the static memory pins
`timescale 1ns/1ps
module sram_model
  import pbm_pkg::*;
(
  input wire logic   clk,
  input wire sram_s  sram,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:65535];
  initial rdata = 8'h5a;
  // byte access driven by the device strobes
  always @(posedge clk) begin
    if (!sram.we_n) mem[sram.addr] <= sram.wdata;
    // a released bus toggles, so stale data is never mistaken for a read
    rdata <= !sram.oe_n ? mem[sram.addr] : ~rdata;
  end
endmodule

// ---- sim/packet_buffer_manager_test.sv ----
// self-checking bench for the packet buffer manager
`timescale 1ns/1ps
module packet_buffer_manager_test;
  import pbm_pkg::*;
  localparam int          DLY  = 1;
  localparam logic [15:0] RING = 16'h1000; // ring base and size: 8k memory, two 2k banks
  logic        clk = 0, rstn = 0, keep_errored = 0, keep_runts = 0, host_wr = 0;
  logic        host_rd = 0, launch = 0, tx_ready = 0, tx_collision = 0, rx_valid = 0;
  logic        rx_end = 0, rx_bad = 0, coll_arm = 0;
  logic        host_wr_ready, host_rd_ready, host_rd_valid, launch_ready, tx_busy;
  logic        tx_valid, tx_last, tx_irq, rx_ready, rx_pending, rx_irq;
  logic [7:0]  host_wdata = 8'h00, rx_data = 8'h00, rx_status = 8'h00;
  logic [7:0]  host_rdata, tx_data, sram_rdata;
  logic [6:0]  queued_frame_count = 7'h00;
  logic [15:0] rnd = 16'h0075, seed = 16'h0075, start = 16'h1000, base = 16'h1000;
  logic [1:0]  mem_size = 2'h0, bank_code = 2'h1;
  logic [7:0]  txq[$], rxq[$], cur[$];
  int          tlen[$];
  int          num_errors = 0, checks = 0, ntxirq = 0, nrx = 0;
  sram_s       sram;

  packet_buffer_manager packet_buffer_manager_i (
    .clk, .rstn, .mem_size, .bank_size_hi(bank_code[1]), .bank_size_lo(bank_code[0]),
    .keep_errored, .keep_runts, .tx_irq_en(1'b1), .host_wr, .host_wdata,
    .host_wr_ready, .host_rd, .host_rd_ready, .host_rdata, .host_rd_valid, .launch,
    .queued_frame_count, .launch_ready, .tx_busy, .tx_data, .tx_valid, .tx_last,
    .tx_ready, .tx_collision, .tx_irq, .rx_valid, .rx_data, .rx_end, .rx_bad,
    .rx_status, .rx_ready, .rx_pending, .rx_irq, .sram, .sram_rdata
  );
  sram_model sram_model_i (.clk, .sram, .rdata(sram_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 clk = ~clk;
  end
  // hang guard, well above the expected run length
  initial begin
    #4000000;
    num_errors++;
    print_verdict();
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tick();
    @(posedge clk);
    #DLY;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // mac side: random stalls, one collision five bytes into a frame when armed
  always @(posedge clk) begin
    #DLY;
    rnd = lfsr(rnd);
    tx_collision = coll_arm && cur.size() == 5;
    if (tx_collision) coll_arm = 0;
    tx_ready = !tx_collision && rnd[1:0] != 2'h0;
  end
  // collect sent bytes per frame; a collision throws the partial frame away
  always @(posedge clk) begin
    if (tx_irq === 1'b1) ntxirq++;
    if (rx_irq === 1'b1) nrx++;
    if (tx_collision) cur.delete();
    else if (tx_valid === 1'b1 && tx_ready) begin
      cur.push_back(tx_data);
      if (tx_last === 1'b1) begin
        chk(16'(cur.size()), 16'(tlen.pop_front()));
        foreach (cur[i]) chk({8'h00, cur[i]}, {8'h00, txq.pop_front()});
        cur.delete();
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic do_reset();
    rstn = 1'b0;
    repeat (16) tick();
    chk({14'h0, host_wr_ready, launch_ready}, 16'h0003);
    chk({13'h0, rx_ready, rx_pending, host_rd_ready}, 16'h0000);
    chk({14'h0, sram.we_n, sram.oe_n}, 16'h0003);
    rstn = 1'b1;
    start = base;
  endtask
  task automatic host_write(input logic [7:0] d);
    while (host_wr_ready !== 1'b1) tick();
    host_wr = 1'b1;
    host_wdata = d;
    tick();
    host_wr = 1'b0;
  endtask
  // length header high byte first, then the frame body
  task automatic tx_frame(input int len);
    host_write(8'(len >> 8));
    host_write(8'(len));
    tlen.push_back(len);
    repeat (len) begin
      seed = lfsr(seed);
      txq.push_back(seed[7:0]);
      host_write(seed[7:0]);
    end
  endtask
  // launch with the count of frames just loaded
  task automatic start_tx(input logic [6:0] n);
    while (launch_ready !== 1'b1) tick();
    launch = 1'b1;
    queued_frame_count = n;
    tick();
    launch = 1'b0;
    chk({15'h0, tx_busy}, 16'h0001);
  endtask
  // valid or end is held until the design takes it
  task automatic rx_put(input logic [7:0] b, input logic last);
    rx_valid = !last;
    rx_end = last;
    rx_data = b;
    while (rx_ready !== 1'b1) tick();
    tick();
  endtask
  task automatic rx_frame(input int len, input logic bad, input logic kept);
    int n0;
    n0 = nrx;
    seed = lfsr(seed);
    rx_status = seed[15:8];
    rx_bad = bad;
    if (kept) rxq.push_back(seed[15:8]);
    if (kept) rxq.push_back(8'h00);
    if (kept) rxq.push_back(8'(len >> 8));
    if (kept) rxq.push_back(8'(len));
    repeat (len) begin
      seed = lfsr(seed);
      if (kept) rxq.push_back(seed[7:0]);
      rx_put(seed[7:0], 1'b0);
    end
    rx_put(8'h00, 1'b1);
    rx_end = 1'b0;
    if (kept) begin
      while (nrx == n0) tick();
      chk({15'h0, rx_pending}, 16'h0001);
      chk({sram_model_i.mem[start + 2], sram_model_i.mem[start + 3]}, 16'(len));
      start = start + ((16'(len) + 16'h000b) & 16'hfff8);
      if (start >= 2 * RING) start = start - RING;
    end else begin
      repeat (60) tick();
      chk(16'(nrx), 16'(n0));
    end
  endtask
  // read stream is header then body
  task automatic drain(input int n);
    repeat (n) begin
      while (host_rd_ready !== 1'b1) tick();
      host_rd = 1'b1;
      tick();
      host_rd = 1'b0;
      while (host_rd_valid !== 1'b1) tick();
      chk({8'h00, host_rdata}, {8'h00, rxq.pop_front()});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    do_reset();
    tx_frame(60);
    tx_frame(61);
    coll_arm = 1'b1;
    start_tx(7'd2);
    // second bank loads while the first is sent
    tx_frame(62);
    start_tx(7'd1);
    while (tx_busy !== 1'b0) tick();
    tick();
    chk({sram_model_i.mem[0], sram_model_i.mem[1]}, 16'd60);
    chk({sram_model_i.mem[62], sram_model_i.mem[63]}, 16'd61);
    chk({sram_model_i.mem[16'h0800], sram_model_i.mem[16'h0801]}, 16'd62);
    chk(16'(ntxirq), 16'd2);
    chk(16'(tlen.size()), 16'd0);
    // fill the ring, then offer a frame that cannot fit
    repeat (50) rx_frame(64, 1'b0, 1'b1);
    rx_frame(1000, 1'b0, 1'b0);
    drain(50 * 68);
    repeat (8) tick();
    chk({15'h0, rx_pending}, 16'h0000);
    // later frames run past the top and wrap to the ring base
    repeat (20) begin
      seed = lfsr(seed);
      n = 60 + int'(seed[5:0]);
      rx_frame(n, 1'b0, 1'b1);
      drain(n + 4);
    end
    // errored and short frames, each with its keep bit off and on
    for (int k = 0; k < 4; k++) begin
      keep_errored = k[0] && !k[1];
      keep_runts = k[0] && k[1];
      // each memory size; single bank, then two 4k banks
      mem_size = 2'(k);
      bank_code = {k[1], 1'b0};
      base = k[1] ? 16'h2000 : 16'h0800;
      do_reset();
      rx_frame(k[1] ? 20 : 64, !k[1], k[0]);
      if (k[0]) drain(k[1] ? 24 : 68);
    end
    print_verdict();
  end
endmodule
